// ==== test/sph_peer.sv ====
// behavioural external serial device on the link pins
`timescale 1ns/1ns
`default_nettype none
module sph_peer #(
  parameter int DIV = 2
) (
  // clock
  input  wire logic ref_clk,
  // link pins
  input  wire logic serial_tx_line,
  input  wire logic send_request_out,
  input  wire logic terminal_ready_out,
  output logic      serial_rx_line,
  output logic      clear_to_send_in,
  output logic      peer_set_ready_in,
  // bench controls
  input  wire logic pause_req,
  input  wire logic ready_drop
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  logic       carrier_detect_in;
  assign carrier_detect_in = terminal_ready_out;
  assign clear_to_send_in  = send_request_out & ~pause_req;
  assign peer_set_ready_in = terminal_ready_out & ~ready_drop;
  initial serial_rx_line = 1'h1;
  task automatic send(input logic [7:0] c);
    logic [10:0] f;
    f = {2'h3, c, 1'h0};
    for (int i = 0; i < 11; i++) begin
      serial_rx_line <= f[i];
      repeat (DIV) @(posedge ref_clk);
    end
  endtask
  initial forever begin
    @(posedge ref_clk);
    if (terminal_ready_out === 1'h1 && carrier_detect_in === 1'h1 &&
        serial_tx_line === 1'h0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge ref_clk);
        sh[i] = serial_tx_line;
      end
      repeat (DIV) @(posedge ref_clk);
      if (serial_tx_line === 1'h1) got_q.push_back(sh);
      repeat (DIV) @(posedge ref_clk);
    end
  end
endmodule
`default_nettype wire

// ==== test/test_serial_port_handshake_control.sv ====
// self-checking bench for the serial port handshake control block
`timescale 1ns/1ns
`default_nettype none
module test_serial_port_handshake_control;
  logic       ref_clk = 1'h0;
  logic       reset_n = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_valid = 1'h0;
  logic       device_ready = 1'h1;
  logic       transfer_active = 1'h0;
  logic       touch_panel_fitted = 1'h0;
  logic       alarm_clear = 1'h0;
  logic       pause = 1'h0;
  logic       drop = 1'h0;
  logic       tx_ready, dsr_lost_alarm, transfer_abort, tx_paused;
  logic       serial_tx_line, send_request_out, terminal_ready_out;
  logic       serial_rx_line, clear_to_send_in, peer_set_ready_in;
  int         err_count = 0;
  int         total_checks = 0;
  int         cyc = 0;

  always #5 ref_clk = ~ref_clk;

  sph_ctrl u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .baud_div(16'h0002), .device_ready(device_ready),
    .transfer_active(transfer_active),
    .touch_panel_fitted(touch_panel_fitted), .alarm_clear(alarm_clear),
    .dsr_lost_alarm(dsr_lost_alarm), .transfer_abort(transfer_abort),
    .tx_paused(tx_paused), .serial_tx_line(serial_tx_line),
    .send_request_out(send_request_out),
    .terminal_ready_out(terminal_ready_out),
    .serial_rx_line(serial_rx_line), .clear_to_send_in(clear_to_send_in),
    .peer_set_ready_in(peer_set_ready_in)
  );

  sph_peer #(.DIV(2)) u_peer (
    .ref_clk(ref_clk), .serial_tx_line(serial_tx_line),
    .send_request_out(send_request_out),
    .terminal_ready_out(terminal_ready_out),
    .serial_rx_line(serial_rx_line), .clear_to_send_in(clear_to_send_in),
    .peer_set_ready_in(peer_set_ready_in),
    .pause_req(pause), .ready_drop(drop)
  );

  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic put(input logic [7:0] b);
    tx_data  <= b;
    tx_valid <= 1'h1;
    tick(1);
    while (tx_ready !== 1'h1) tick(1);
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 400 && u_peer.got_q.size() < n; i++) tick(1);
    chk(8'(u_peer.got_q.size()), 8'(n));
  endtask

  task automatic t_basic;
    put(8'ha5);
    put(8'h3c);
    tx_valid <= 1'h0;
    tick(2);
    chk(send_request_out, 1'h1);
    wait_rx(2);
    chk(u_peer.got_q[0], 8'ha5);
    chk(u_peer.got_q[1], 8'h3c);
    tick(8);
    chk(send_request_out, 1'h0);
    u_peer.got_q.delete();
  endtask

  task automatic t_cts;
    pause <= 1'h1;
    put(8'h01);
    put(8'h02);
    tx_valid <= 1'h0;
    tick(40);
    chk(tx_ready, 1'h0);
    chk(serial_tx_line, 1'h1);
    chk(8'(u_peer.got_q.size()), 8'h00);
    pause <= 1'h0;
    while (serial_tx_line !== 1'h0) tick(1);
    pause <= 1'h1;
    tick(60);
    chk(8'(u_peer.got_q.size()), 8'h01);
    chk(u_peer.got_q[0], 8'h01);
    pause <= 1'h0;
    wait_rx(2);
    chk(u_peer.got_q[1], 8'h02);
    u_peer.got_q.delete();
  endtask

  task automatic t_halt;
    u_peer.send(8'h93);
    tick(4);
    chk(tx_paused, 1'h1);
    put(8'h55);
    tx_valid <= 1'h0;
    tick(60);
    chk(8'(u_peer.got_q.size()), 8'h00);
    u_peer.send(8'h11);
    tick(4);
    chk(tx_paused, 1'h0);
    wait_rx(1);
    chk(u_peer.got_q[0], 8'h55);
    u_peer.got_q.delete();
  endtask

  task automatic t_loss;
    logic seen;
    put(8'h77);
    tx_valid <= 1'h0;
    while (serial_tx_line !== 1'h0) tick(1);
    tick(4);
    drop <= 1'h1;
    seen = 1'h0;
    for (int i = 0; i < 6; i++) begin
      tick(1);
      seen = seen | (transfer_abort === 1'h1);
    end
    chk(dsr_lost_alarm, 1'h1);
    chk(seen, 1'h1);
    chk(serial_tx_line, 1'h1);
    drop <= 1'h0;
    tick(30);
    chk(dsr_lost_alarm, 1'h1);
    alarm_clear <= 1'h1;
    tick(1);
    alarm_clear <= 1'h0;
    tick(2);
    chk(dsr_lost_alarm, 1'h0);
    transfer_active <= 1'h1;
    drop <= 1'h1;
    tick(5);
    chk(dsr_lost_alarm, 1'h1);
    chk(tx_ready, 1'h0);
    transfer_active <= 1'h0;
    drop <= 1'h0;
    tick(1);
    alarm_clear <= 1'h1;
    tick(1);
    alarm_clear <= 1'h0;
    tick(2);
    chk(dsr_lost_alarm, 1'h0);
    u_peer.got_q.delete();
  endtask

  task automatic t_misc;
    touch_panel_fitted <= 1'h1;
    tick(3);
    chk(tx_ready, 1'h0);
    touch_panel_fitted <= 1'h0;
    device_ready <= 1'h0;
    tick(3);
    chk(terminal_ready_out, 1'h0);
    device_ready <= 1'h1;
    tick(3);
    chk(terminal_ready_out, 1'h1);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end

  initial begin
    tick(2);
    chk(serial_tx_line, 1'h1);
    chk(send_request_out, 1'h0);
    reset_n <= 1'h1;
    tick(3);
    t_basic;
    t_cts;
    t_halt;
    t_loss;
    t_misc;
    test_done;
  end
endmodule
`default_nettype wire

// ==== verilog/sph_buf.sv ====
// two-entry character buffer between user port and transmitter
`timescale 1ns/1ns
`default_nettype none
`include "sph_cfg.svh"
module sph_buf (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // filling side
  input  wire logic [`SPH_DATA_W-1:0] in_data,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  // draining side
  output logic [`SPH_DATA_W-1:0]     out_data,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  // discard contents and refuse while high
  input  wire logic                  flush
);
  sph_pkg::sph_buf_t state_reg;
  sph_pkg::sph_buf_t state_next;
  logic              push;
  logic              pop;

  assign in_ready  = state_reg.rdy;
  assign out_valid = state_reg.vld;
  assign out_data  = state_reg.mem[state_reg.rp];

  always_comb begin
    state_next = state_reg;
    push = in_valid && state_reg.rdy;
    pop  = out_ready && state_reg.vld;
    if (push) begin
      state_next.mem[state_reg.wp] = in_data;
      state_next.wp = ~state_reg.wp;
    end
    if (pop) begin
      state_next.rp = ~state_reg.rp;
    end
    if (push && !pop) begin
      state_next.cnt = state_reg.cnt + `SPH_ONE_CNT;
    end else if (pop && !push) begin
      state_next.cnt = state_reg.cnt - `SPH_ONE_CNT;
    end
    if (flush) begin
      state_next.cnt = `SPH_BUF_EMPTY;
      state_next.rp  = state_next.wp;
    end
    state_next.rdy = !flush && (state_next.cnt != `SPH_BUF_DEPTH);
    state_next.vld = state_next.cnt != `SPH_BUF_EMPTY;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  buf_bound_a: assert property (state_reg.cnt <= `SPH_BUF_DEPTH)
    else $error("buffer count beyond depth");
  buf_full_a: assert property (state_reg.cnt == `SPH_BUF_DEPTH |-> !in_ready)
    else $error("buffer full but ready");
endmodule
`default_nettype wire

// ==== verilog/sph_cfg.svh ====
// constants for the serial port handshake control block
`ifndef SPH_CFG_SVH
`define SPH_CFG_SVH
`define SPH_DATA_W     8
`define SPH_DIV_W      16
`define SPH_FRAME_W    11
`define SPH_LAST_BIT   4'ha
`define SPH_LAST_RXBIT 4'h7
`define SPH_STOP_PAIR  2'h3
`define SPH_START_BIT  1'h0
`define SPH_LINE_IDLE  1'h1
`define SPH_CODE_MASK  8'h7f
`define SPH_CODE_GO    8'h11
`define SPH_CODE_HALT  8'h13
`define SPH_BUF_DEPTH  2'h2
`define SPH_BUF_EMPTY  2'h0
`define SPH_ONE_CNT    2'h1
`define SPH_SYNC_IDLE  2'h3
`define SPH_FIRST_STOP 4'h9
`endif

// ==== verilog/sph_ctrl.sv ====
// serial port transmit and receive handshake control
//
// Behaviour
// - send request high from start to end of sending
// - send only with clear-to-send and peer ready
// - clear-to-send drop halts within two characters
// - peer ready lost mid-transfer aborts, raises alarm
// - terminal ready out while block is operable
// - touch panel fitted blocks this channel's data
// - one start, eight data, two stop bits
// - halt code stops output, go code resumes
`timescale 1ns/1ns
`default_nettype none
`include "sph_cfg.svh"
module sph_ctrl (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  // user character stream
  input  wire logic [`SPH_DATA_W-1:0] tx_data,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  // control and status
  input  wire logic [`SPH_DIV_W-1:0]  baud_div,
  input  wire logic                   device_ready,
  input  wire logic                   transfer_active,
  input  wire logic                   touch_panel_fitted,
  input  wire logic                   alarm_clear,
  output logic                        dsr_lost_alarm,
  output logic                        transfer_abort,
  output logic                        tx_paused,
  // link pins
  output logic                        serial_tx_line,
  output logic                        send_request_out,
  output logic                        terminal_ready_out,
  input  wire logic                   serial_rx_line,
  input  wire logic                   clear_to_send_in,
  input  wire logic                   peer_set_ready_in
);
  sph_pkg::sph_ctrl_t       state_reg;
  sph_pkg::sph_ctrl_t       state_next;
  logic [`SPH_DATA_W-1:0]   buf_data;
  logic                     buf_valid;
  logic                     take;
  logic                     flush;
  logic                     cts_s;
  logic                     dsr_s;
  logic                     rx_s;
  logic                     tx_tick;
  logic                     lost;
  logic [`SPH_DATA_W-1:0]   code;

  // true on the last cycle of a period of lim cycles
  function automatic logic period_end(input logic [`SPH_DIV_W-1:0] cnt,
                                      input logic [`SPH_DIV_W-1:0] lim);
    period_end = ({1'b0, cnt} + {{`SPH_DIV_W{1'b0}}, 1'b1}) >= {1'b0, lim};
  endfunction

  assign cts_s = state_reg.cts_sy[1];
  assign dsr_s = state_reg.dsr_sy[1];
  assign rx_s  = state_reg.rx_sy[1];

  assign serial_tx_line     = state_reg.line;
  assign send_request_out   = state_reg.rts;
  assign terminal_ready_out = state_reg.dtr;
  assign dsr_lost_alarm     = state_reg.alarm;
  assign transfer_abort     = state_reg.abort;
  assign tx_paused          = state_reg.xoff;

  sph_buf u_buf (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (take),
    .flush     (flush)
  );

  always_comb begin
    state_next = state_reg;
    code = '0;
    // two-stage synchronisers, first stage read only by the second
    state_next.cts_sy = {state_reg.cts_sy[0], clear_to_send_in};
    state_next.dsr_sy = {state_reg.dsr_sy[0], peer_set_ready_in};
    state_next.rx_sy  = {state_reg.rx_sy[0], serial_rx_line};
    state_next.dtr    = device_ready;
    state_next.abort  = 1'b0;
    tx_tick = period_end(state_reg.tx_div, baud_div);
    lost = !dsr_s && (transfer_active || state_reg.tx_st == sph_pkg::tx_send);
    flush = lost || touch_panel_fitted;
    take = 1'b0;

    // transmitter
    case (state_reg.tx_st)
      sph_pkg::tx_idle: begin
        state_next.line = `SPH_LINE_IDLE;
        if (buf_valid && cts_s && dsr_s && !state_reg.xoff && !flush) begin
          take = 1'b1;
          state_next.tx_sh  = {`SPH_STOP_PAIR, buf_data, `SPH_START_BIT};
          state_next.tx_bit = '0;
          state_next.tx_div = '0;
          state_next.line   = `SPH_START_BIT;
          state_next.tx_st  = sph_pkg::tx_send;
        end
      end
      sph_pkg::tx_send: begin
        state_next.tx_div = state_reg.tx_div + 1'b1;
        if (tx_tick) begin
          state_next.tx_div = '0;
          if (state_reg.tx_bit == `SPH_LAST_BIT) begin
            state_next.tx_st = sph_pkg::tx_idle;
            state_next.line  = `SPH_LINE_IDLE;
          end else begin
            state_next.tx_bit = state_reg.tx_bit + 1'b1;
            state_next.tx_sh  = state_reg.tx_sh >> 1;
            state_next.line   = state_reg.tx_sh[1];
          end
        end
      end
      default: begin
        state_next.tx_st = sph_pkg::tx_idle;
      end
    endcase

    // peer lost or channel given to the touch panel: stop at once
    if (flush) begin
      state_next.tx_st = sph_pkg::tx_idle;
      state_next.line  = `SPH_LINE_IDLE;
    end
    if (lost) begin
      state_next.abort = 1'b1;
    end
    // set wins over clear
    state_next.alarm = lost || (state_reg.alarm && !alarm_clear);

    // request held while a character waits or is on the line
    state_next.rts = !flush && (state_next.tx_st == sph_pkg::tx_send ||
                                buf_valid);

    // receiver watching for flow control codes
    state_next.rx_div = state_reg.rx_div + 1'b1;
    case (state_reg.rx_st)
      sph_pkg::rx_idle: begin
        state_next.rx_div = '0;
        if (!rx_s) begin
          state_next.rx_st = sph_pkg::rx_start;
        end
      end
      sph_pkg::rx_start: begin
        if (period_end(state_reg.rx_div, baud_div >> 1)) begin
          state_next.rx_div = '0;
          state_next.rx_bit = '0;
          state_next.rx_st  = rx_s ? sph_pkg::rx_idle : sph_pkg::rx_data;
        end
      end
      sph_pkg::rx_data: begin
        if (period_end(state_reg.rx_div, baud_div)) begin
          state_next.rx_div = '0;
          state_next.rx_sh  = {rx_s, state_reg.rx_sh[`SPH_DATA_W-1:1]};
          state_next.rx_bit = state_reg.rx_bit + 1'b1;
          if (state_reg.rx_bit == `SPH_LAST_RXBIT) begin
            state_next.rx_st = sph_pkg::rx_stop;
            code = state_next.rx_sh & `SPH_CODE_MASK;
            if (code == `SPH_CODE_HALT) begin
              state_next.xoff = 1'b1;
            end else if (code == `SPH_CODE_GO) begin
              state_next.xoff = 1'b0;
            end
          end
        end
      end
      sph_pkg::rx_stop: begin
        if (rx_s) begin
          state_next.rx_st = sph_pkg::rx_idle;
        end
      end
      default: begin
        state_next.rx_st = sph_pkg::rx_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg       <= '0;
      state_reg.line  <= `SPH_LINE_IDLE;
      // receive synchroniser starts at idle level, no false start bit
      state_reg.rx_sy <= `SPH_SYNC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  tx_gate_a: assert property (
    state_reg.tx_st == sph_pkg::tx_idle ##1
    state_reg.tx_st == sph_pkg::tx_send |-> $past(cts_s && dsr_s))
    else $error("character started without both handshakes");
  rts_hold_a: assert property (
    state_reg.tx_st == sph_pkg::tx_send |-> send_request_out)
    else $error("send request low while sending");
  rts_drop_a: assert property (
    state_reg.tx_st == sph_pkg::tx_idle && !buf_valid |=> !send_request_out)
    else $error("send request held after transmission");
  start_bit_a: assert property (
    state_reg.tx_st == sph_pkg::tx_idle && take |=> !serial_tx_line [*1]
    ##0 state_reg.tx_st == sph_pkg::tx_send)
    else $error("start bit missing");
  stop_bits_a: assert property (
    state_reg.tx_st == sph_pkg::tx_send &&
    state_reg.tx_bit >= `SPH_FIRST_STOP
    |-> serial_tx_line)
    else $error("stop bit not high");
  cts_halt_a: assert property (
    !cts_s && state_reg.tx_st == sph_pkg::tx_idle
    |=> state_reg.tx_st == sph_pkg::tx_idle)
    else $error("new character while clear-to-send low");
  alarm_set_a: assert property (
    lost |=> dsr_lost_alarm && transfer_abort && serial_tx_line
    ##1 (!transfer_abort || $past(lost)))
    else $error("peer loss not aborted");
  ready_out_a: assert property (
    $past(reset_n) |-> terminal_ready_out == $past(device_ready))
    else $error("terminal ready does not follow device ready");
  tp_block_a: assert property (
    touch_panel_fitted |=> !send_request_out && !tx_ready)
    else $error("channel active while touch panel fitted");
  xoff_hold_a: assert property (
    state_reg.xoff && state_reg.tx_st == sph_pkg::tx_idle
    |=> state_reg.tx_st == sph_pkg::tx_idle)
    else $error("character sent while halted by peer code");
  sync_a: assert property (
    cts_s == $past(clear_to_send_in, 2))
    else $error("clear-to-send not two stages");
  bit_time_a: assert property (
    state_reg.tx_st == sph_pkg::tx_send && !tx_tick && !flush
    |=> $stable(serial_tx_line))
    else $error("line changed inside a bit period");

  char_sent_c: cover property (
    state_reg.tx_st == sph_pkg::tx_send ##1 state_reg.tx_st == sph_pkg::tx_idle);
  alarm_c: cover property (lost);
  xoff_c: cover property ($rose(state_reg.xoff) ##[1:1000] $fell(state_reg.xoff));
endmodule
`default_nettype wire

// ==== verilog/sph_pkg.sv ====
// types shared by the serial port handshake control modules
`include "sph_cfg.svh"
package sph_pkg;
  typedef enum logic [0:0] {tx_idle, tx_send} sph_tx_st_t;
  typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} sph_rx_st_t;

  typedef struct packed {
    logic [1:0][`SPH_DATA_W-1:0] mem;
    logic                        wp;
    logic                        rp;
    logic [1:0]                  cnt;
    logic                        rdy;
    logic                        vld;
  } sph_buf_t;

  typedef struct packed {
    sph_tx_st_t                  tx_st;
    sph_rx_st_t                  rx_st;
    logic [`SPH_FRAME_W-1:0]     tx_sh;
    logic [3:0]                  tx_bit;
    logic [`SPH_DIV_W-1:0]       tx_div;
    logic [`SPH_DATA_W-1:0]      rx_sh;
    logic [3:0]                  rx_bit;
    logic [`SPH_DIV_W-1:0]       rx_div;
    logic [1:0]                  cts_sy;
    logic [1:0]                  dsr_sy;
    logic [1:0]                  rx_sy;
    logic                        xoff;
    logic                        line;
    logic                        rts;
    logic                        dtr;
    logic                        alarm;
    logic                        abort;
  } sph_ctrl_t;
endpackage
